// ==== rate_setup_pkg.sv ====
// Notes on behaviour
// - only 125k, 250k, 500k and 1M CAN bit rates are ever selected
// - stored setup table holds the power-on rate and an apply-rate flag
// - valid table with apply flag set starts CAN at the table rate
// - table rate may be firmware-default code, which means 500k
// - valid table without apply flag uses the last rate set by table or master, or 500k when none was ever set
// - invalid table uses the last set rate when one was ever set
// - invalid table and nothing ever set starts at 500k
// - image is text blocks split by one empty line ending the block
// - block starts with address line; first value goes to that address, each later one to the next address up
// - addresses and data are hex of at most four digits; longer rejected
// - one value per line; short values zero-extended on the left
// - master may set node id and bit timing through layer settings
package rate_setup_pkg;
   // =====================================================
   // rate codes
   typedef enum logic [2:0] {
      RATE_125K = 3'h0,
      RATE_250K = 3'h1,
      RATE_500K = 3'h2,
      RATE_1M = 3'h3,
      RATE_FW_DEFAULT = 3'h4
   } rate_t;
   localparam rate_t DEFAULT_RATE = RATE_500K;
   localparam logic [3:0] MAX_DIGITS = 4'h4;
   localparam logic [7:0] CHAR_LF = 8'h0a;
   localparam logic [7:0] CHAR_CR = 8'h0d;
   // =====================================================
   // memory write word carried through the fifo
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
   } nv_write_t;
   localparam int NV_WRITE_W = 32;
   typedef enum logic [1:0] {
      LD_ADDR = 2'h0,
      LD_DATA = 2'h1,
      LD_SKIP = 2'h3
   } load_state_t;
endpackage : rate_setup_pkg

// ==== can_rate_setup_loader.sv ====
`timescale 1ns/1ps
// =====================================================
// fifo
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("depth must be power of 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp;
   logic [AW:0] rp;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // ready is registered from the next fill, so the text side sees a flop
   // and not a path through the pointer arithmetic
   wire [AW:0] next_wp = wp + (AW+1)'(push);
   wire [AW:0] next_rp = rp + (AW+1)'(pop);
   assign out_valid = wp != rp;
   assign out_data = mem[rp[AW-1:0]];
   always_ff @(posedge clk) begin
      if (push) mem[wp[AW-1:0]] <= in_data;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         wp <= '0;
         rp <= '0;
         in_ready <= 1'b1;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         in_ready <= (next_wp - next_rp) != (AW+1)'(DEPTH);
      end
   end
   chk_fifo_no_over: assert property (@(posedge clk) disable iff (srst)
      (wp - rp) <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
   chk_fifo_ready: assert property (@(posedge clk) disable iff (srst)
      in_ready == ((wp - rp) != (AW+1)'(DEPTH)))
      else $error("ready out of step with fill");
endmodule : word_fifo

// =====================================================
// top
module can_rate_setup_loader #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   // power-on rate choice inputs
   input wire logic boot_start,
   input wire logic table_valid,
   input wire logic table_apply,
   input wire rate_setup_pkg::rate_t table_rate,
   input wire logic nv_last_set,
   input wire rate_setup_pkg::rate_t nv_last_rate,
   // layer-setting service from the network master
   input wire logic lss_valid,
   input wire rate_setup_pkg::rate_t lss_rate,
   input wire logic [6:0] lss_node_id,
   output rate_setup_pkg::rate_t can_rate,
   output logic can_rate_valid,
   output logic [6:0] node_id,
   output logic last_set,
   output rate_setup_pkg::rate_t last_rate,
   output logic last_store,
   // setup image text stream
   input wire logic [7:0] img_char,
   input wire logic img_valid,
   output logic img_ready,
   output logic img_error,
   // memory writes
   output logic [15:0] nv_addr,
   output logic [15:0] nv_data,
   output logic nv_valid,
   input wire logic nv_ready
);
   // =====================================================
   // rate choice
   function automatic rate_setup_pkg::rate_t legal(rate_setup_pkg::rate_t r);
      legal = (r > rate_setup_pkg::RATE_1M) ? rate_setup_pkg::DEFAULT_RATE
                                            : r;
   endfunction : legal
   wire rate_setup_pkg::rate_t boot_choice =
      (table_valid && table_apply) ? legal(table_rate) :
      nv_last_set ? legal(nv_last_rate) :
      rate_setup_pkg::DEFAULT_RATE;
   wire boot_store = table_valid && table_apply;
   always_ff @(posedge clk) begin
      if (srst) begin
         can_rate <= rate_setup_pkg::DEFAULT_RATE;
         can_rate_valid <= 1'b0;
         node_id <= 7'h00;
         last_set <= 1'b0;
         last_rate <= rate_setup_pkg::DEFAULT_RATE;
         last_store <= 1'b0;
      end else begin
         last_store <= 1'b0;
         if (lss_valid) begin
            can_rate <= legal(lss_rate);
            node_id <= lss_node_id;
            can_rate_valid <= 1'b1;
            last_set <= 1'b1;
            last_rate <= legal(lss_rate);
            last_store <= 1'b1;
         end else if (boot_start) begin
            can_rate <= boot_choice;
            can_rate_valid <= 1'b1;
            last_set <= boot_store || nv_last_set;
            last_rate <= boot_store ? legal(table_rate) : legal(nv_last_rate);
            last_store <= boot_store;
         end
      end
   end
   chk_rate_apply: assert property (@(posedge clk) disable iff (srst)
      boot_start && !lss_valid && table_valid && table_apply
      && table_rate <= rate_setup_pkg::RATE_1M |=> can_rate == $past(table_rate))
      else $error("table rate not applied");
   chk_fw_default: assert property (@(posedge clk) disable iff (srst)
      boot_start && !lss_valid && table_valid && table_apply
      && table_rate == rate_setup_pkg::RATE_FW_DEFAULT
      |=> can_rate == rate_setup_pkg::RATE_500K)
      else $error("firmware default not 500k");
   chk_rate_default: assert property (@(posedge clk) disable iff (srst)
      boot_start && !lss_valid && !table_valid && !nv_last_set
      |=> can_rate == rate_setup_pkg::RATE_500K)
      else $error("default rate missing");
   chk_rate_fallback: assert property (@(posedge clk)
      disable iff (srst)
      boot_start && !lss_valid && !(table_valid && table_apply) && nv_last_set
      && nv_last_rate <= rate_setup_pkg::RATE_1M
      |=> can_rate == $past(nv_last_rate))
      else $error("last rate not used");
   chk_rate_legal: assert property (@(posedge clk) disable iff (srst)
      can_rate <= rate_setup_pkg::RATE_1M) else $error("bad rate");
   chk_lss_take: assert property (@(posedge clk) disable iff (srst)
      lss_valid |=> node_id == $past(lss_node_id) && last_set && last_store)
      else $error("lss not taken");

   // =====================================================
   // image parser
   rate_setup_pkg::load_state_t st;
   logic [15:0] acc;
   logic [3:0] digits;
   logic [15:0] addr;
   logic line_has;
   logic fifo_in_ready;
   wire is_nl = img_char == rate_setup_pkg::CHAR_LF;
   wire is_cr = img_char == rate_setup_pkg::CHAR_CR;
   wire is_09 = img_char >= 8'h30 && img_char <= 8'h39;
   wire is_af = img_char >= 8'h61 && img_char <= 8'h66;
   wire is_uaf = img_char >= 8'h41 && img_char <= 8'h46;
   wire is_hex = is_09 || is_af || is_uaf;
   wire [3:0] nib = is_09 ? img_char[3:0] : 4'(img_char[3:0] + 4'h9);
   // a stalled fifo holds the character, so a data line never drops
   wire take = img_valid && img_ready;
   wire data_end = take && is_nl && line_has && st == rate_setup_pkg::LD_DATA;
   wire rate_setup_pkg::nv_write_t wr = '{addr: addr, data: acc};
   wire rate_setup_pkg::nv_write_t rd;
   logic fifo_out_valid;
   assign img_ready = fifo_in_ready;
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= rate_setup_pkg::LD_ADDR;
         acc <= 16'h0000;
         digits <= 4'h0;
         addr <= 16'h0000;
         line_has <= 1'b0;
         img_error <= 1'b0;
      end else if (take) begin
         if (is_nl) begin
            acc <= 16'h0000;
            digits <= 4'h0;
            line_has <= 1'b0;
            if (!line_has) begin
               st <= rate_setup_pkg::LD_ADDR;
            end else if (st == rate_setup_pkg::LD_ADDR) begin
               addr <= acc;
               st <= rate_setup_pkg::LD_DATA;
            end else if (st == rate_setup_pkg::LD_DATA) begin
               addr <= addr + 16'h0001;
            end
         end else if (st == rate_setup_pkg::LD_SKIP) begin
            // text in a skipped line keeps it non-blank, so only a true
            // blank line ends the skip and resyncs on an address
            line_has <= line_has || !is_cr;
         end else if (is_hex) begin
            if (digits == rate_setup_pkg::MAX_DIGITS) begin
               img_error <= 1'b1;
               st <= rate_setup_pkg::LD_SKIP;
               line_has <= 1'b1;
            end else begin
               acc <= {acc[11:0], nib};
               digits <= digits + 4'h1;
               line_has <= 1'b1;
            end
         end else if (!is_cr) begin
            img_error <= 1'b1;
            st <= rate_setup_pkg::LD_SKIP;
            line_has <= 1'b1;
         end
      end
   end
   chk_long_reject: assert property (@(posedge clk) disable iff (srst)
      take && is_hex && digits == rate_setup_pkg::MAX_DIGITS
      && st != rate_setup_pkg::LD_SKIP
      |=> img_error && st == rate_setup_pkg::LD_SKIP)
      else $error("long value accepted");
   chk_addr_step: assert property (@(posedge clk) disable iff (srst)
      data_end |=> addr == $past(addr) + 16'h0001)
      else $error("address not stepped");
   chk_blank_ends: assert property (@(posedge clk) disable iff (srst)
      take && is_nl && !line_has |=> st == rate_setup_pkg::LD_ADDR)
      else $error("block not ended");
   chk_skip_holds: assert property (@(posedge clk) disable iff (srst)
      take && is_nl && line_has && st == rate_setup_pkg::LD_SKIP
      |=> st == rate_setup_pkg::LD_SKIP)
      else $error("skip ended early");

   word_fifo #(.WIDTH(rate_setup_pkg::NV_WRITE_W), .DEPTH(FIFO_DEPTH)) fifo (
      .clk(clk),
      .srst(srst),
      .in_data(wr),
      .in_valid(data_end),
      .in_ready(fifo_in_ready),
      .out_data(rd),
      .out_valid(fifo_out_valid),
      .out_ready(!nv_valid || nv_ready)
   );
   // output stage register so the memory port comes from flip-flops
   always_ff @(posedge clk) begin
      if (srst) begin
         nv_valid <= 1'b0;
         nv_addr <= 16'h0000;
         nv_data <= 16'h0000;
      end else if (!nv_valid || nv_ready) begin
         nv_valid <= fifo_out_valid;
         nv_addr <= rd.addr;
         nv_data <= rd.data;
      end
   end
endmodule : can_rate_setup_loader

// ==== nv_sink.sv ====
`timescale 1ns/1ps
// ==========
// memory side: takes writes, stalls while hold_off is set
module nv_sink (
   input wire logic clk,
   input wire logic srst,
   input wire logic hold_off,
   output logic nv_ready
);
   // ready moves only after an edge, so a stall never cuts a write short
   always_ff @(posedge clk) begin
      nv_ready <= !srst && !hold_off;
   end
endmodule : nv_sink

// ==== can_rate_setup_loader_bench.sv ====
`timescale 1ns/1ps
module can_rate_setup_loader_bench;
   logic clk, srst, boot_start, table_valid, table_apply, nv_last_set;
   logic lss_valid, img_valid, img_ready, img_error, nv_valid, nv_ready;
   logic can_rate_valid, last_set, last_store, hold_off;
   logic [6:0] lss_node_id, node_id;
   logic [7:0] img_char;
   logic [15:0] nv_addr, nv_data;
   logic [31:0] seed;
   rate_setup_pkg::rate_t table_rate, nv_last_rate, lss_rate;
   rate_setup_pkg::rate_t can_rate, last_rate, e;
   rate_setup_pkg::nv_write_t exp_q[$];
   int failures, comparisons;
   can_rate_setup_loader #(.FIFO_DEPTH(8)) dut (.clk(clk), .srst(srst),
      .boot_start(boot_start), .table_valid(table_valid),
      .table_apply(table_apply), .table_rate(table_rate),
      .nv_last_set(nv_last_set), .nv_last_rate(nv_last_rate),
      .lss_valid(lss_valid), .lss_rate(lss_rate),
      .lss_node_id(lss_node_id), .can_rate(can_rate),
      .can_rate_valid(can_rate_valid), .node_id(node_id),
      .last_set(last_set), .last_rate(last_rate), .last_store(last_store),
      .img_char(img_char), .img_valid(img_valid), .img_ready(img_ready),
      .img_error(img_error), .nv_addr(nv_addr), .nv_data(nv_data),
      .nv_valid(nv_valid), .nv_ready(nv_ready));
   nv_sink mem (.clk(clk), .srst(srst), .hold_off(hold_off),
      .nv_ready(nv_ready));
   // ==========
   // helpers
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic rate_setup_pkg::rate_t exp_rate(logic v, logic a,
      rate_setup_pkg::rate_t t, logic s, rate_setup_pkg::rate_t l);
      if (v && a && t != rate_setup_pkg::RATE_FW_DEFAULT) return t;
      if (!(v && a) && s) return l;
      return rate_setup_pkg::DEFAULT_RATE;
   endfunction : exp_rate
   task automatic chk_rate(rate_setup_pkg::rate_t got,
      rate_setup_pkg::rate_t exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: rate %0d not %0d", $time, got, exp);
      end
   endtask : chk_rate
   task automatic chk_word(logic [15:0] got, logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic put(logic [7:0] c);
      int n;
      logic rdy;
      n = 0;
      @(posedge clk);
      img_char <= c;
      img_valid <= 1'b1;
      // ready is read before the edge that takes the character
      do begin
         @(negedge clk);
         rdy = img_ready;
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      img_valid <= 1'b0;
      if (rdy !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: text stream stuck", $time);
      end
   endtask : put
   // a value of nd digits, most significant first, then line end
   task automatic line(logic [15:0] v, int nd);
      for (int i = nd - 1; i >= 0; i--) begin
         put(v[i*4+:4] < 10 ? 8'h30 + v[i*4+:4] : 8'h57 + v[i*4+:4]);
      end
      put(rate_setup_pkg::CHAR_LF);
   endtask : line
   task automatic drain;
      for (int i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge clk);
      chk_word(16'(exp_q.size()), 16'h0000);
   endtask : drain
   task automatic results;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   // ==========
   // write monitor
   always @(posedge clk) begin
      if (nv_valid === 1'b1 && nv_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk_word(nv_addr, 16'hxxxx);
         end else begin
            chk_word(nv_addr, exp_q[0].addr);
            chk_word(nv_data, exp_q[0].data);
            void'(exp_q.pop_front());
         end
      end
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #3000000;
      failures++;
      results();
   end
   // ==========
   // tests
   initial begin
      {srst, boot_start, table_valid, table_apply, nv_last_set} = 5'h10;
      {lss_valid, img_valid, hold_off, img_char, lss_node_id} = 0;
      table_rate = rate_setup_pkg::RATE_125K;
      nv_last_rate = rate_setup_pkg::RATE_125K;
      lss_rate = rate_setup_pkg::RATE_125K;
      failures = 0;
      comparisons = 0;
      seed = 32'h5240;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         @(posedge clk);
         {table_valid, table_apply, nv_last_set} <= seed[2:0];
         table_rate <= rate_setup_pkg::rate_t'(3'(seed[7:3] % 5));
         nv_last_rate <= rate_setup_pkg::rate_t'({1'b0, seed[9:8]});
         boot_start <= 1'b1;
         @(posedge clk);
         boot_start <= 1'b0;
         e = exp_rate(table_valid, table_apply, table_rate, nv_last_set,
            nv_last_rate);
         @(negedge clk);
         chk_rate(can_rate, e);
         chk_word(16'(last_store), 16'(table_valid & table_apply));
         chk_word(16'(can_rate_valid), 16'h0001);
         chk_word(16'(last_set),
            16'((table_valid & table_apply) | nv_last_set));
         chk_rate(last_rate,
            (table_valid & table_apply) ? e : nv_last_rate);
      end
      $display("boot rate test done");
      for (int r = 0; r < 4; r++) begin
         seed = lfsr(seed);
         @(posedge clk);
         lss_rate <= rate_setup_pkg::rate_t'(r);
         lss_node_id <= seed[6:0];
         lss_valid <= 1'b1;
         @(posedge clk);
         lss_valid <= 1'b0;
         @(negedge clk);
         chk_rate(can_rate, rate_setup_pkg::rate_t'(r));
         chk_word(16'(node_id), 16'(lss_node_id));
         chk_rate(last_rate, rate_setup_pkg::rate_t'(r));
         chk_word(16'(last_store), 16'h0001);
      end
      $display("layer setting test done");
      line(16'h0010, 2);
      exp_q.push_back('{16'h0010, 16'h0005});
      line(16'h0005, 1);
      for (int i = 1; i < 6; i++) begin
         seed = lfsr(seed);
         exp_q.push_back('{16'h0010 + 16'(i), seed[15:0]});
         line(seed[15:0], 4);
      end
      put(rate_setup_pkg::CHAR_LF);
      drain();
      // a stalled memory must back the text stream up, not drop words
      hold_off <= 1'b1;
      line(16'hfff0, 4);
      for (int i = 0; i < 9; i++) begin
         exp_q.push_back('{16'hfff0 + 16'(i), 16'(i * 16'h1111)});
         line(16'(i * 16'h1111), 4);
      end
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk_word(16'(img_ready), 16'h0000);
      hold_off <= 1'b0;
      put(rate_setup_pkg::CHAR_LF);
      drain();
      $display("image block test done");
      line(16'h0020, 2);
      put(8'h31);
      line(16'h2345, 4);
      // lines after a rejected entry stay skipped until the blank line
      for (int i = 7; i < 10; i++) line(16'(i), 1);
      put(rate_setup_pkg::CHAR_LF);
      exp_q.push_back('{16'h0030, 16'h0001});
      line(16'h0030, 2);
      line(16'h0001, 1);
      put(rate_setup_pkg::CHAR_LF);
      drain();
      chk_word(16'(img_error), 16'h0001);
      $display("long entry test done");
      results();
   end
endmodule : can_rate_setup_loader_bench
